// File: abpb_pkg.sv
// Shared constants and state encoding for the backplane bus processor interface
package abpb_pkg;
    localparam int CLK_MHZ = 125;
    localparam int HALT_MIN_NS = 25000;
    localparam int HALT_CYCLES = (HALT_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int INIT_HOLD_NS = 10000;
    localparam int INIT_CYCLES = (INIT_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int HALT_CNT_W = 12;
    localparam int INIT_CNT_W = 11;
    localparam logic [15:0] EVENT_VECTOR = 16'h0040;
    localparam logic [2:0] LEVEL_FOUR = 3'h4;
    localparam logic [2:0] LEVEL_FIVE = 3'h5;
    localparam logic [2:0] LEVEL_SIX = 3'h6;
    localparam logic [2:0] LEVEL_SEVEN = 3'h7;
    // Bit positions inside the synchronised control group
    localparam int SY_SYNC = 0;
    localparam int SY_RPLY = 1;
    localparam int SY_DMR = 2;
    localparam int SY_SACK = 3;
    localparam int SY_HALT = 4;
    localparam int SY_EVNT = 5;
    localparam int SY_POK = 6;
    localparam int SY_IRQ4 = 7;
    localparam int SY_CTRL_W = 11;

    typedef enum logic [3:0] {
        ABPB_IDLE = 4'h0,
        ABPB_ADDR = 4'h1,
        ABPB_SYNC = 4'h3,
        ABPB_DATA = 4'h2,
        ABPB_WAIT = 4'h6,
        ABPB_END = 4'h7,
        ABPB_IAK = 4'h5,
        ABPB_IAK_END = 4'h4,
        ABPB_GRANT = 4'hC,
        ABPB_DMA = 4'hD,
        ABPB_INIT = 4'hF
    } abpb_state_t;
endpackage

// File: abpb_sync.sv
// Two-flop synchroniser for asynchronous bus lines
`timescale 1ns/1ns
`default_nettype none
module abpb_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stage <= '0;
            sync_out <= '0;
        end else begin
            stage <= async_in;
            sync_out <= stage;
        end
    end
endmodule
`default_nettype wire

// File: abpb_processor.sv
// Processor end of the asynchronous backplane bus: arbiter, master cycles, traps
// How it works
// - Grant only when idle, sync not driven
// - Stop request held 25 us halts, masks interrupts
// - Refresh strobe marks refreshing sync/data-in cycles
// - Power-good drop while running starts power-fail trap
// - External event traps through vector 100 octal
// - Write completes only on slave reply
// - Slave replies to read, write, acknowledge
// - Read: data-in during sync, awaits reply
// - Data-in without sync is interrupt acknowledge
// - Level four acknowledged when status bit 7 clear
// - Acknowledge out confirms interrupt receipt
// - Separate request lines for levels 5-7
// - Upper lines: address, then error data/enable
// - Bus initialize returns everyone to state zero
`timescale 1ns/1ns
`default_nettype none
module abpb_processor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Core command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic cmd_byte,
    input wire logic cmd_refresh,
    input wire logic [17:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    input wire logic cmd_err_enable,
    input wire logic init_request,
    // Core answers
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic rsp_mem_error,
    // Core status and traps
    input wire logic [2:0] psw_priority,
    output logic halted,
    output logic halt_entry,
    output logic power_fail_trap,
    output logic event_trap,
    output logic irq_taken,
    output logic [15:0] trap_vector,
    // Data/address lines, active low
    input wire logic [17:0] data_address_lines_n_in,
    output logic [17:0] data_address_lines_n_out,
    output logic data_address_lines_oe_n,
    output logic data_address_upper_oe_n,
    // Strobes driven by the processor, open drain
    output logic transfer_sync_n_out,
    output logic transfer_sync_oe_n,
    input wire logic transfer_sync_n_in,
    output logic data_in_strobe_n_out,
    output logic data_in_strobe_oe_n,
    output logic data_out_strobe_n_out,
    output logic data_out_strobe_oe_n,
    output logic write_byte_select_n_out,
    output logic write_byte_select_oe_n,
    output logic refresh_strobe_n_out,
    output logic refresh_strobe_oe_n,
    output logic bus_initialize_n_out,
    output logic bus_initialize_oe_n,
    // Lines received from the bus
    input wire logic slave_reply_n,
    input wire logic dma_request_n,
    input wire logic select_acknowledge_n,
    input wire logic processor_stop_request_n,
    input wire logic external_event_request_n,
    input wire logic ac_power_good,
    input wire logic irq_level_four_n,
    input wire logic irq_level_five_n,
    input wire logic irq_level_six_n,
    input wire logic irq_level_seven_n,
    // Daisy-chain heads
    output logic dma_grant_out_n,
    output logic int_ack_out_n
);
    typedef struct packed {
        abpb_pkg::abpb_state_t state;
        logic [abpb_pkg::HALT_CNT_W-1:0] halt_cnt;
        logic [abpb_pkg::INIT_CNT_W-1:0] init_cnt;
        logic [17:0] addr;
        logic [15:0] wdata;
        logic write;
        logic byte_sel;
        logic refresh;
        logic err_enable;
        logic rsp_valid;
        logic [15:0] rdata;
        logic mem_error;
        logic halted;
        logic halt_pulse;
        logic pf_pulse;
        logic evt_pulse;
        logic irq_pulse;
        logic [15:0] vector;
        logic pok_prev;
        logic evt_prev;
        logic [17:0] dal;
        logic dal_oe;
        logic dal_hi_oe;
        logic sync;
        logic din;
        logic dout;
        logic wtbt;
        logic ref_on;
        logic iako;
        logic dmgo;
        logic init;
    } abpb_regs_t;

    abpb_regs_t r;
    abpb_regs_t next_r;
    logic [abpb_pkg::SY_CTRL_W-1:0] ctrl;
    logic [17:0] dal_in;

    // Whether any pending level is above the status word priority
    function automatic logic irq_allowed(input logic [3:0] req, input logic [2:0] prio);
        logic ok;
        ok = 1'b0;
        if (req[3] && prio < abpb_pkg::LEVEL_SEVEN) ok = 1'b1;
        if (req[2] && prio < abpb_pkg::LEVEL_SIX) ok = 1'b1;
        if (req[1] && prio < abpb_pkg::LEVEL_FIVE) ok = 1'b1;
        if (req[0] && prio < abpb_pkg::LEVEL_FOUR) ok = 1'b1;
        return ok;
    endfunction

    abpb_sync #(.WIDTH(abpb_pkg::SY_CTRL_W)) u_ctrl_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in({~irq_level_seven_n, ~irq_level_six_n, ~irq_level_five_n,
            ~irq_level_four_n, ac_power_good, ~external_event_request_n,
            ~processor_stop_request_n, ~select_acknowledge_n, ~dma_request_n,
            ~slave_reply_n, ~transfer_sync_n_in}),
        .sync_out(ctrl)
    );

    abpb_sync #(.WIDTH(18)) u_dal_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .async_in(~data_address_lines_n_in),
        .sync_out(dal_in)
    );

    logic reply;
    logic [3:0] irq_req;
    logic irq_go;
    logic dma_go;
    assign reply = ctrl[abpb_pkg::SY_RPLY];
    assign irq_req = ctrl[abpb_pkg::SY_IRQ4 +: 4];
    assign irq_go = irq_allowed(irq_req, psw_priority) && !r.halted;
    assign dma_go = ctrl[abpb_pkg::SY_DMR] && !ctrl[abpb_pkg::SY_SYNC];
    assign cmd_ready = (r.state == abpb_pkg::ABPB_IDLE) && !init_request && !dma_go && !irq_go;

    always_comb begin
        next_r = r;
        next_r.rsp_valid = 1'b0;
        next_r.halt_pulse = 1'b0;
        next_r.pf_pulse = 1'b0;
        next_r.evt_pulse = 1'b0;
        next_r.irq_pulse = 1'b0;
        next_r.pok_prev = ctrl[abpb_pkg::SY_POK];
        next_r.evt_prev = ctrl[abpb_pkg::SY_EVNT];

        // Stop request qualified over the minimum hold time
        if (!ctrl[abpb_pkg::SY_HALT]) begin
            next_r.halt_cnt = '0;
            next_r.halted = 1'b0;
        end else if (r.halt_cnt != abpb_pkg::HALT_CYCLES[abpb_pkg::HALT_CNT_W-1:0] - 1'b1) begin
            next_r.halt_cnt = r.halt_cnt + 1'b1;
        end else if (!r.halted) begin
            next_r.halted = 1'b1;
            next_r.halt_pulse = 1'b1;
        end

        if (r.pok_prev && !ctrl[abpb_pkg::SY_POK] && !r.halted) begin
            next_r.pf_pulse = 1'b1;
        end
        if (ctrl[abpb_pkg::SY_EVNT] && !r.evt_prev && !r.halted) begin
            next_r.evt_pulse = 1'b1;
            next_r.vector = abpb_pkg::EVENT_VECTOR;
        end

        unique case (r.state)
            abpb_pkg::ABPB_IDLE: begin
                if (init_request) begin
                    next_r.state = abpb_pkg::ABPB_INIT;
                    next_r.init = 1'b1;
                    next_r.init_cnt = '0;
                end else if (dma_go) begin
                    next_r.state = abpb_pkg::ABPB_GRANT;
                    next_r.dmgo = 1'b1;
                end else if (irq_go) begin
                    next_r.state = abpb_pkg::ABPB_IAK;
                    next_r.din = 1'b1;
                    next_r.iako = 1'b1;
                end else if (cmd_valid) begin
                    next_r.state = abpb_pkg::ABPB_ADDR;
                    next_r.addr = cmd_addr;
                    next_r.wdata = cmd_wdata;
                    next_r.write = cmd_write;
                    next_r.byte_sel = cmd_byte;
                    next_r.refresh = cmd_refresh && !cmd_write;
                    next_r.err_enable = cmd_err_enable;
                    next_r.dal = cmd_addr;
                    next_r.dal_oe = 1'b1;
                    next_r.dal_hi_oe = 1'b1;
                    next_r.wtbt = cmd_write;
                    next_r.ref_on = cmd_refresh && !cmd_write;
                end
            end
            abpb_pkg::ABPB_ADDR: begin
                next_r.state = abpb_pkg::ABPB_SYNC;
                next_r.sync = 1'b1;
            end
            abpb_pkg::ABPB_SYNC: begin
                next_r.state = abpb_pkg::ABPB_DATA;
                next_r.dal[17] = r.err_enable;
                next_r.dal[16] = 1'b0;
                if (r.write) begin
                    next_r.dal[15:0] = r.wdata;
                    next_r.wtbt = r.byte_sel;
                end else begin
                    next_r.dal_oe = 1'b0;
                    next_r.wtbt = 1'b0;
                end
            end
            abpb_pkg::ABPB_DATA: begin
                // Data already stable one cycle before the strobe
                next_r.state = abpb_pkg::ABPB_WAIT;
                if (r.write) begin
                    next_r.dout = 1'b1;
                end else begin
                    next_r.din = 1'b1;
                end
            end
            abpb_pkg::ABPB_WAIT: begin
                if (reply) begin
                    next_r.state = abpb_pkg::ABPB_END;
                    next_r.din = 1'b0;
                    next_r.dout = 1'b0;
                    next_r.wtbt = 1'b0;
                    next_r.rdata = r.write ? 16'h0000 : dal_in[15:0];
                    next_r.mem_error = !r.write && r.err_enable && dal_in[16];
                end
            end
            abpb_pkg::ABPB_END: begin
                if (!reply) begin
                    next_r.state = abpb_pkg::ABPB_IDLE;
                    next_r.sync = 1'b0;
                    next_r.dal_oe = 1'b0;
                    next_r.dal_hi_oe = 1'b0;
                    next_r.ref_on = 1'b0;
                    next_r.rsp_valid = 1'b1;
                end
            end
            abpb_pkg::ABPB_IAK: begin
                if (reply) begin
                    next_r.state = abpb_pkg::ABPB_IAK_END;
                    next_r.din = 1'b0;
                    next_r.iako = 1'b0;
                    next_r.vector = dal_in[15:0];
                end
            end
            abpb_pkg::ABPB_IAK_END: begin
                if (!reply) begin
                    next_r.state = abpb_pkg::ABPB_IDLE;
                    next_r.irq_pulse = 1'b1;
                end
            end
            abpb_pkg::ABPB_GRANT: begin
                if (ctrl[abpb_pkg::SY_SACK]) begin
                    next_r.state = abpb_pkg::ABPB_DMA;
                    next_r.dmgo = 1'b0;
                end else if (!ctrl[abpb_pkg::SY_DMR]) begin
                    next_r.state = abpb_pkg::ABPB_IDLE;
                    next_r.dmgo = 1'b0;
                end
            end
            abpb_pkg::ABPB_DMA: begin
                if (!ctrl[abpb_pkg::SY_SACK] && !ctrl[abpb_pkg::SY_SYNC]) begin
                    next_r.state = abpb_pkg::ABPB_IDLE;
                end
            end
            abpb_pkg::ABPB_INIT: begin
                if (r.init_cnt == abpb_pkg::INIT_CYCLES[abpb_pkg::INIT_CNT_W-1:0] - 1'b1) begin
                    next_r.state = abpb_pkg::ABPB_IDLE;
                    next_r.init = 1'b0;
                end else begin
                    next_r.init_cnt = r.init_cnt + 1'b1;
                end
            end
            default: begin
                next_r.state = abpb_pkg::ABPB_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            r <= '0;
            r.state <= abpb_pkg::ABPB_INIT;
            r.init <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign rsp_valid = r.rsp_valid;
    assign rsp_rdata = r.rdata;
    assign rsp_mem_error = r.mem_error;
    assign halted = r.halted;
    assign halt_entry = r.halt_pulse;
    assign power_fail_trap = r.pf_pulse;
    assign event_trap = r.evt_pulse;
    assign irq_taken = r.irq_pulse;
    assign trap_vector = r.vector;
    assign data_address_lines_n_out = ~r.dal;
    assign data_address_lines_oe_n = ~r.dal_oe;
    assign data_address_upper_oe_n = ~r.dal_hi_oe;
    assign transfer_sync_n_out = 1'b0;
    assign transfer_sync_oe_n = ~r.sync;
    assign data_in_strobe_n_out = 1'b0;
    assign data_in_strobe_oe_n = ~r.din;
    assign data_out_strobe_n_out = 1'b0;
    assign data_out_strobe_oe_n = ~r.dout;
    assign write_byte_select_n_out = 1'b0;
    assign write_byte_select_oe_n = ~r.wtbt;
    assign refresh_strobe_n_out = 1'b0;
    assign refresh_strobe_oe_n = ~r.ref_on;
    assign bus_initialize_n_out = 1'b0;
    assign bus_initialize_oe_n = ~r.init;
    assign dma_grant_out_n = ~r.dmgo;
    assign int_ack_out_n = ~r.iako;
endmodule
`default_nettype wire

// File: abpb_processor_asserts.sv
// Concurrent checks on the processor end of the backplane bus
`timescale 1ns/1ns
`default_nettype none
module abpb_processor_asserts (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Command port
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic cmd_write,
    input wire logic cmd_byte,
    input wire logic cmd_refresh,
    // Strobe enables
    input wire logic transfer_sync_oe_n,
    input wire logic data_in_strobe_oe_n,
    input wire logic data_out_strobe_oe_n,
    input wire logic write_byte_select_oe_n,
    input wire logic refresh_strobe_oe_n,
    input wire logic data_address_lines_oe_n,
    // Received lines and chain heads
    input wire logic slave_reply_n,
    input wire logic processor_stop_request_n,
    input wire logic ac_power_good,
    input wire logic dma_grant_out_n,
    input wire logic int_ack_out_n,
    // Traps
    input wire logic halted,
    input wire logic halt_entry,
    input wire logic event_trap,
    input wire logic power_fail_trap,
    input wire logic [15:0] trap_vector
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic [12:0] stop_cnt;
    // Length of the current stop request at the pin
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            stop_cnt <= 13'h0000;
        end else if (processor_stop_request_n) begin
            stop_cnt <= 13'h0000;
        end else if (stop_cnt != 13'h1fff) begin
            stop_cnt <= stop_cnt + 13'h0001;
        end
    end
    sequence take_word; cmd_valid && cmd_ready && cmd_write && !cmd_byte; endsequence
    sequence take_byte; cmd_valid && cmd_ready && cmd_write && cmd_byte; endsequence
    sequence take_read; cmd_valid && cmd_ready && !cmd_write; endsequence
    sequence addr_phase; !write_byte_select_oe_n ##1 !transfer_sync_oe_n; endsequence
    write_lead_a: assert property (cmd_valid && cmd_ready && cmd_write |=> addr_phase)
        else $error("write marker missing at sync edge");
    word_out_a: assert property (take_word |-> ##[3:6]
        (!data_out_strobe_oe_n && write_byte_select_oe_n)) else $error("word data-out wrong");
    byte_out_a: assert property (take_byte |-> ##[3:6]
        (!data_out_strobe_oe_n && !write_byte_select_oe_n)) else $error("byte data-out wrong");
    read_in_a: assert property (take_read |-> ##[3:6] (!data_in_strobe_oe_n &&
        !transfer_sync_oe_n && data_address_lines_oe_n && write_byte_select_oe_n))
        else $error("read data-in phase wrong");
    refresh_read_a: assert property (take_read and cmd_refresh |->
        ##[1:2] !refresh_strobe_oe_n) else $error("refresh strobe missing on read");
    dout_reply_a: assert property ($rose(data_out_strobe_oe_n) |-> !$past(slave_reply_n, 2))
        else $error("data-out released before reply");
    iak_nosync_a: assert property (!int_ack_out_n |->
        transfer_sync_oe_n && !data_in_strobe_oe_n) else $error("acknowledge cycle malformed");
    grant_idle_a: assert property ($fell(dma_grant_out_n) |->
        transfer_sync_oe_n && $past(transfer_sync_oe_n)) else $error("grant during own cycle");
    halt_time_a: assert property (halt_entry |-> stop_cnt >= abpb_pkg::HALT_CYCLES)
        else $error("halt before stop time");
    halt_mask_a: assert property (halted |-> int_ack_out_n)
        else $error("interrupt acknowledged while halted");
    event_vec_a: assert property (event_trap |-> ##[0:1] trap_vector == 16'h0040)
        else $error("event vector wrong");
    power_fail_a: assert property (power_fail_trap |-> !$past(ac_power_good))
        else $error("power fail trap without power drop");
endmodule
bind abpb_processor abpb_processor_asserts u_chk (
    .sys_clk, .reset, .cmd_valid, .cmd_ready, .cmd_write, .cmd_byte, .cmd_refresh,
    .transfer_sync_oe_n, .data_in_strobe_oe_n, .data_out_strobe_oe_n,
    .write_byte_select_oe_n, .refresh_strobe_oe_n, .data_address_lines_oe_n,
    .slave_reply_n, .processor_stop_request_n, .ac_power_good, .dma_grant_out_n,
    .int_ack_out_n, .halted, .halt_entry, .event_trap, .power_fail_trap, .trap_vector
);
`default_nettype wire

// File: abpb_slave_model.sv
// Memory slave and interrupting device on the far side of the bus
`timescale 1ns/1ns
`default_nettype none
module abpb_slave_model (
    // Clock
    input wire logic sys_clk,
    // Bus strobes and lines, active low
    input wire logic sync_n,
    input wire logic din_n,
    input wire logic dout_n,
    input wire logic wtbt_n,
    input wire logic [17:0] dal_n,
    // Reply delay and acknowledge vector
    input wire logic [3:0] delay,
    input wire logic [15:0] vector,
    // Answer
    output logic reply_n,
    output logic dal_oe,
    output logic [17:0] dal_drv_n
);
    logic [15:0] mem [int];
    logic [17:0] addr = 18'h0_0000;
    logic [15:0] w;
    always @(negedge sync_n) addr = ~dal_n;
    initial begin
        reply_n = 1'b1;
        dal_oe = 1'b0;
        dal_drv_n = 18'h3_ffff;
        forever begin
            @(posedge sys_clk);
            if (!din_n || !dout_n) begin
                repeat (delay) @(posedge sys_clk);
                w = mem.exists(addr[17:1]) ? mem[addr[17:1]] : 16'h0000;
                if (!dout_n) begin
                    if (wtbt_n) w = ~dal_n[15:0];
                    else if (addr[0]) w[15:8] = ~dal_n[15:8];
                    else w[7:0] = ~dal_n[7:0];
                    mem[addr[17:1]] = w;
                end else begin
                    dal_drv_n <= ~{2'b00, sync_n ? vector : w};
                    dal_oe <= 1'b1;
                end
                reply_n <= 1'b0;
                wait (din_n && dout_n);
                @(posedge sys_clk);
                reply_n <= 1'b1;
                dal_oe <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: abpb_processor_test.sv
// Self-checking bench for the processor end of the backplane bus
`timescale 1ns/1ns
`default_nettype none
module abpb_processor_test;
    logic sys_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, cmd_write = 1'b0;
    logic cmd_byte = 1'b0, cmd_refresh = 1'b0, cmd_err_enable = 1'b0, ac_power_good = 1'b1;
    logic dma_request_n = 1'b1, select_acknowledge_n = 1'b1, external_event_request_n = 1'b1;
    logic processor_stop_request_n = 1'b1;
    logic [3:0] irq_n = 4'hf, delay = 4'h0, vec_due = 4'h0;
    logic [2:0] psw_priority = 3'h3;
    logic [17:0] cmd_addr = 18'h0_0000, data_address_lines_n_out, dal_drv_n, a;
    logic [15:0] cmd_wdata = 16'h0000, iak_vector = 16'h0000, rsp_rdata, trap_vector, w, v;
    logic cmd_ready, rsp_valid, halted, halt_entry, power_fail_trap, event_trap, irq_taken;
    logic data_address_lines_oe_n, data_address_upper_oe_n, transfer_sync_oe_n, dal_oe;
    logic data_in_strobe_oe_n, data_out_strobe_oe_n, write_byte_select_oe_n;
    logic dma_grant_out_n, int_ack_out_n, slave_reply_n;
    logic init_request = 1'b0, init_oe_n, mem_err;
    wire logic transfer_sync_n_in;
    wire logic [17:0] data_address_lines_n_in;
    logic [19:0] exp_q[$];
    int mismatches = 0, checks_done = 0, cycles = 0, seed = 94, i;
    always #4 sys_clk = ~sys_clk;
    // Wire levels: open drain with pull-up, released lines read high
    assign transfer_sync_n_in = transfer_sync_oe_n;
    assign data_address_lines_n_in = (dal_oe ? dal_drv_n : 18'h3_ffff) &
        {data_address_upper_oe_n ? 2'b11 : data_address_lines_n_out[17:16],
        data_address_lines_oe_n ? 16'hffff : data_address_lines_n_out[15:0]};
    abpb_processor u_dut (
        .sys_clk, .reset, .cmd_valid, .cmd_ready, .cmd_write, .cmd_byte, .cmd_refresh,
        .cmd_addr, .cmd_wdata, .cmd_err_enable, .init_request, .rsp_valid, .rsp_rdata,
        .rsp_mem_error(mem_err), .psw_priority, .halted, .halt_entry, .power_fail_trap,
        .event_trap,
        .irq_taken, .trap_vector, .data_address_lines_n_in, .data_address_lines_n_out,
        .data_address_lines_oe_n, .data_address_upper_oe_n, .transfer_sync_n_out(),
        .transfer_sync_oe_n, .transfer_sync_n_in, .data_in_strobe_n_out(),
        .data_in_strobe_oe_n, .data_out_strobe_n_out(), .data_out_strobe_oe_n,
        .write_byte_select_n_out(), .write_byte_select_oe_n, .refresh_strobe_n_out(),
        .refresh_strobe_oe_n(), .bus_initialize_n_out(), .bus_initialize_oe_n(init_oe_n),
        .slave_reply_n, .dma_request_n, .select_acknowledge_n, .processor_stop_request_n,
        .external_event_request_n, .ac_power_good, .irq_level_four_n(irq_n[0]),
        .irq_level_five_n(irq_n[1]), .irq_level_six_n(irq_n[2]),
        .irq_level_seven_n(irq_n[3]), .dma_grant_out_n, .int_ack_out_n
    );
    abpb_slave_model u_slave (
        .sys_clk, .sync_n(transfer_sync_n_in), .din_n(data_in_strobe_oe_n),
        .dout_n(data_out_strobe_oe_n), .wtbt_n(write_byte_select_oe_n),
        .dal_n(data_address_lines_n_in), .delay, .vector(iak_vector),
        .reply_n(slave_reply_n), .dal_oe, .dal_drv_n
    );
    task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic take(input logic [19:0] seen);
        check("result", seen, exp_q.size() != 0 ? exp_q.pop_front() : 20'hx_xxxx);
    endtask
    task automatic complete_run;
        if (mismatches == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic bus_cmd(input logic wr, input logic by, input logic rf,
        input logic [17:0] ad, input logic [15:0] d, input logic [15:0] e);
        exp_q.push_back({4'h1, e});
        @(negedge sys_clk);
        while (cmd_ready !== 1'b1) @(negedge sys_clk);
        {cmd_valid, cmd_write, cmd_byte, cmd_refresh} = {1'b1, wr, by, rf};
        cmd_addr = ad;
        cmd_wdata = d;
        cmd_err_enable = 1'($random(seed));
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(negedge sys_clk);
    endtask
    // Results in order of issue
    always @(negedge sys_clk) begin
        if (vec_due != 4'h0) take({vec_due, trap_vector});
        vec_due = event_trap === 1'b1 ? 4'h3 : (irq_taken === 1'b1 ? 4'h2 : 4'h0);
        if (rsp_valid === 1'b1) take({4'h1, rsp_rdata});
        if (rsp_valid === 1'b1) check("mem error", mem_err, 1'b0);
        if (power_fail_trap === 1'b1) take(20'h4_0000);
        if (halt_entry === 1'b1) take(20'h5_0000);
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        check("init after reset", init_oe_n, 1'b0);
        // Word write, byte into one lane, read back; slave speed varies
        for (i = 0; i < 8; i++) begin
            a = 18'($random(seed));
            a[0] = 1'b0;
            w = 16'($random(seed));
            v = 16'($random(seed));
            delay = 4'($random(seed));
            bus_cmd(1'b1, 1'b0, 1'b0, a, w, 16'h0000);
            if (i[0]) w[15:8] = v[15:8];
            else w[7:0] = v[7:0];
            bus_cmd(1'b1, 1'b1, 1'b0, {a[17:1], i[0]}, v, 16'h0000);
            bus_cmd(1'b0, 1'b0, i[1], a, 16'h0000, w);
        end
        exp_q.push_back(20'h3_0040);
        external_event_request_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        external_event_request_n = 1'b1;
        exp_q.push_back(20'h4_0000);
        ac_power_good = 1'b0;
        repeat (6) @(negedge sys_clk);
        ac_power_good = 1'b1;
        // Each request level acknowledged with the device's vector
        for (i = 0; i < 4; i++) begin
            iak_vector = 16'($random(seed));
            exp_q.push_back({4'h2, iak_vector});
            irq_n[i] = 1'b0;
            while (int_ack_out_n !== 1'b0) @(negedge sys_clk);
            irq_n[i] = 1'b1;
            while (irq_taken !== 1'b1) @(negedge sys_clk);
        end
        psw_priority = 3'h4;
        irq_n[0] = 1'b0;
        bus_cmd(1'b0, 1'b0, 1'b0, a, 16'h0000, w);
        check("masked ack", int_ack_out_n, 1'b1);
        irq_n[0] = 1'b1;
        // Let the released request clear the synchroniser before unmasking
        repeat (3) @(negedge sys_clk);
        psw_priority = 3'h3;
        dma_request_n = 1'b0;
        while (dma_grant_out_n !== 1'b0) @(negedge sys_clk);
        dma_request_n = 1'b1;
        select_acknowledge_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("ready in dma", cmd_ready, 1'b0);
        select_acknowledge_n = 1'b1;
        exp_q.push_back(20'h5_0000);
        processor_stop_request_n = 1'b0;
        repeat (3200) @(negedge sys_clk);
        irq_n[3] = 1'b0;
        repeat (20) @(negedge sys_clk);
        check("halted", halted, 1'b1);
        check("ack in halt", int_ack_out_n, 1'b1);
        irq_n[3] = 1'b1;
        repeat (4) @(negedge sys_clk);
        processor_stop_request_n = 1'b1;
        repeat (10) @(negedge sys_clk);
        check("halt released", halted, 1'b0);
        init_request = 1'b1;
        @(negedge sys_clk);
        init_request = 1'b0;
        check("bus init", init_oe_n, 1'b0);
        check("pending", 20'(exp_q.size()), 20'h0_0000);
        complete_run();
    end
endmodule
`default_nettype wire
